// >>> hw/spi_flags_pkg.sv
package spi_flags_pkg;
  // Register offsets on the plain register port
  localparam logic [3:0] STATUS_ADDR = 4'h0;
  localparam logic [3:0] CONTROL_ADDR = 4'h4;
  localparam logic [3:0] IRQ_STATUS_ADDR = 4'h8;
  localparam logic [3:0] IRQ_MASK_ADDR = 4'hC;
  // Status field positions
  localparam int RXCNT_LSB = 24;
  localparam int TXCNT_LSB = 16;
  localparam int FRAME_ERROR_FLAG_BIT = 12;
  localparam int BUSY_BIT = 11;
  localparam int TUR_BIT = 8;
  localparam int SHIFTER_EMPTY_FLAG_BIT = 7;
  localparam int ROV_BIT = 6;
  localparam int RBE_BIT = 5;
  localparam int TBE_BIT = 3;
  localparam int TBF_BIT = 1;
  localparam int RBF_BIT = 0;
  // Control field positions
  localparam int CTL_ON_BIT = 0;
  localparam int CTL_DEEP_BIT = 1;
  localparam int CTL_FRM_BIT = 2;
  localparam int CTL_IGNORE_OVERFLOW_BIT = 3;
  localparam int CTL_IGNORE_UNDERRUN_BIT = 4;
  // Interrupt bit positions
  localparam int IRQ_ROV = 0;
  localparam int IRQ_TUR = 1;
  localparam int IRQ_FRM = 2;
  localparam int IRQ_W = 3;
  // Buffer geometry
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam logic [PTR_W-1:0] PTR_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  // Link quiet time in clock cycles; longer than a half period of the link clock
  localparam int QUIET_W = 6;
  localparam logic [QUIET_W-1:0] LINK_QUIET = 6'h30;
  localparam logic [QUIET_W-1:0] QUIET_ONE = 6'h01;
  localparam logic [QUIET_W-1:0] QUIET_ZERO = 6'h00;
  // Event strobes and status levels from the shifting datapath
  typedef struct packed {
    logic tx_load;    // Word moved from holding buffer to shifter
    logic rx_deliver; // Word delivered to receive buffer
    logic rx_complete; // Word fully received
    logic frame_err;  // Frame error detected
    logic underrun;   // Transmit underrun in framed sync mode
    logic shifter_full; // Shifter holds data
    logic active;     // Transaction in progress
  } shift_events_t;
  // Buffer pointers of the deep buffer
  typedef struct packed {
    logic [PTR_W-1:0] cpu_read_pointer;
    logic [PTR_W-1:0] shifter_write_pointer;
    logic [PTR_W-1:0] cpu_write_pointer;
    logic [PTR_W-1:0] shifter_read_pointer;
  } buf_ptrs_t;
endpackage : spi_flags_pkg

// >>> hw/spi_status_flag_logic.sv
// Operation
// RQ1: Receive element count reported in bits 28-24, valid in deep buffer mode.
// RQ2: Transmit element count reported in bits 20-16, valid in deep buffer mode.
// RQ3: Frame error sets bit 12 in framed mode; software clears it.
// RQ4: Bit 11 high while any transaction runs, low when idle.
// RQ5: Underrun sets bit 8; cleared by off/on cycle or writing zero.
// RQ6: Bit 7 shows shifter empty in deep buffer mode.
// RQ7: Overflow bit 6 sets when a word arrives before the previous was read.
// RQ8: Overflow clears only by off/on cycle or software writing zero.
// RQ9: Bit 5 shows receive FIFO empty when read and write pointers match.
// RQ10: Bit 3 sets on word move to shifter, clears on data write, resets one.
// RQ11: Standard mode bit 1 sets on data write, clears on move to shifter.
// RQ12: Deep mode transmit full when write pointer plus one equals read pointer.
// RQ13: Standard mode bit 0 sets on delivery, clears on data read.
// RQ14: Deep mode receive full when write pointer plus one equals read pointer.
// RQ15: All unimplemented status bits read zero.
// RQ16: Overflow without ignore setting halts serial operation.
// RQ17: Underrun without ignore setting halts serial operation.
// RQ18: Writes to read-only status bits are ignored.
// RQ19: Element counts read zero after reset and when disabled.
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module spi_status_flag_logic (
  input wire logic mclk_i, // 250 MHz clock
  input wire logic resetn_i, // Async active-low reset
  input wire logic [3:0] addr_i, // Register byte address
  input wire logic [31:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  input wire logic data_wr_i, // Software wrote the data window
  input wire logic data_rd_i, // Software read the data window
  input wire spi_flags_pkg::shift_events_t ev_i, // Datapath events
  input wire spi_flags_pkg::buf_ptrs_t ptrs_i, // Deep buffer pointers
  input wire logic link_sck_i, // Serial clock from the link
  output logic [31:0] rdata_o, // Read data, cycle after strobe
  output logic irq_o, // Level interrupt
  output logic halt_o, // Serial operation halted
  output logic module_on_o, // Module enable
  output logic deep_buffer_select_o, // Deep buffer selected
  output logic framed_mode_enable_o // Framed mode enabled
);
  import spi_flags_pkg::*;

  logic rst_s1, rst_n;
  logic [4:0] ctl;
  logic tx_buffer_empty_flag, tx_std_full, rx_std_full;
  logic rx_overflow_flag, tx_underrun_flag, frame_error_flag;
  logic [CNT_W-1:0] tx_element_count, rx_element_count;
  logic [IRQ_W-1:0] irq_stat, irq_mask, irq_set;
  logic sck_s1, sck_s2, sck_s3, link_busy;
  logic [31:0] serial_port_status;
  logic on, deep, sw_stat_wr, halt;
  // Link quiet timer, deep receive full and interrupt edge helpers
  logic [QUIET_W-1:0] sck_quiet;
  logic sck_edge;
  logic rx_deep_full;
  logic [IRQ_W-1:0] irq_prev, irq_rise;

  assign on = ctl[CTL_ON_BIT];
  assign deep = ctl[CTL_DEEP_BIT];
  assign sw_stat_wr = wr_i && (addr_i == STATUS_ADDR);
  // Any change of the synchronised link clock is an edge
  assign sck_edge = sck_s2 ^ sck_s3;
  // Deep receive buffer full; a word completing now has nowhere to go
  assign rx_deep_full = ((ptrs_i.shifter_write_pointer + PTR_ONE) == ptrs_i.cpu_read_pointer);

  // Reset release through two flip-flops
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // Link clock synchroniser; reset value matches the idle-low link clock
  // so no false edge follows reset, and the edge compares the second and third stages
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
    end else begin
      sck_s1 <= link_sck_i;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
    end
  end

  // Quiet timer: every link edge restarts it, so busy spans a whole frame
  // instead of pulsing once per edge; a frame cut short simply lets the
  // timer run out and busy falls by itself
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      sck_quiet <= QUIET_ZERO;
    end else if (sck_edge) begin
      sck_quiet <= LINK_QUIET;
    end else if (sck_quiet != QUIET_ZERO) begin
      sck_quiet <= sck_quiet - QUIET_ONE;
    end
  end

  // Link activity level
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      link_busy <= 1'b0;
    end else begin
      link_busy <= sck_edge || (sck_quiet != QUIET_ZERO); // RQ4
    end
  end

  // Control register
  // Clearing the enable bit is the hardware clear of every error flag,
  // count and halt below; the interrupt status and mask keep their bits
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctl <= 5'h00;
    end else if (wr_i && (addr_i == CONTROL_ADDR)) begin
      ctl <= wdata_i[4:0];
    end
  end

  // Transmit empty flag, resets to one
  // A load into the shifter wins over a data write in the same cycle,
  // since the written word then waits behind the one just taken
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_buffer_empty_flag <= 1'b1;
    end else if (!on) begin
      tx_buffer_empty_flag <= 1'b1;
    end else if (ev_i.tx_load) begin
      tx_buffer_empty_flag <= 1'b1; // RQ10
    end else if (data_wr_i) begin
      tx_buffer_empty_flag <= 1'b0; // RQ10
    end
  end

  // Standard mode transmit full
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_std_full <= 1'b0;
    end else if (!on) begin
      tx_std_full <= 1'b0;
    end else if (data_wr_i) begin
      tx_std_full <= 1'b1; // RQ11
    end else if (ev_i.tx_load) begin
      tx_std_full <= 1'b0; // RQ11
    end
  end

  // Standard mode receive full
  // A delivery wins over a read in the same cycle: the new word is unread
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_std_full <= 1'b0;
    end else if (!on) begin
      rx_std_full <= 1'b0;
    end else if (ev_i.rx_deliver) begin
      rx_std_full <= 1'b1; // RQ13
    end else if (data_rd_i) begin
      rx_std_full <= 1'b0; // RQ13
    end
  end

  // Receive overflow: a completed word finds the receive side still full;
  // the full test follows the buffer mode. Hardware set wins over a clear
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_overflow_flag <= 1'b0;
    end else if (!on) begin
      rx_overflow_flag <= 1'b0; // RQ8
    end else if (ev_i.rx_complete && (deep ? rx_deep_full : rx_std_full)) begin
      rx_overflow_flag <= 1'b1; // RQ7
    end else if (sw_stat_wr && !wdata_i[ROV_BIT]) begin
      rx_overflow_flag <= 1'b0; // RQ8
    end
  end

  // Transmit underrun, only in framed operation; set wins over a clear
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_underrun_flag <= 1'b0;
    end else if (!on) begin
      tx_underrun_flag <= 1'b0; // RQ5
    end else if (ev_i.underrun && ctl[CTL_FRM_BIT]) begin
      tx_underrun_flag <= 1'b1; // RQ5
    end else if (sw_stat_wr && !wdata_i[TUR_BIT]) begin
      tx_underrun_flag <= 1'b0; // RQ5
    end
  end

  // Frame error, only in framed operation; set wins over a clear
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      frame_error_flag <= 1'b0;
    end else if (!on) begin
      frame_error_flag <= 1'b0;
    end else if (ev_i.frame_err && ctl[CTL_FRM_BIT]) begin
      frame_error_flag <= 1'b1; // RQ3
    end else if (sw_stat_wr && !wdata_i[FRAME_ERROR_FLAG_BIT]) begin
      frame_error_flag <= 1'b0; // RQ3
    end
  end

  // Critical error halt
  // The halt latches: clearing the flag does not restart the link, only
  // an off/on cycle of the module does, so software must re-enable it
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      halt <= 1'b0;
    end else if (!on) begin
      halt <= 1'b0;
    end else if (rx_overflow_flag && !ctl[CTL_IGNORE_OVERFLOW_BIT]) begin
      halt <= 1'b1; // RQ16
    end else if (tx_underrun_flag && !ctl[CTL_IGNORE_UNDERRUN_BIT]) begin
      halt <= 1'b1; // RQ17
    end
  end

  // Transmit element count from the pointer difference, zero unless on and deep
  // The pointers wrap at the buffer depth, so a 4-bit difference is exact;
  // the top count bit stays zero and the count lags the pointers one cycle
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_element_count <= CNT_ZERO; // RQ19
    end else if (!on || !deep) begin
      tx_element_count <= CNT_ZERO; // RQ19
    end else begin
      tx_element_count <= {1'b0, ptrs_i.cpu_write_pointer - ptrs_i.shifter_read_pointer}; // RQ2
    end
  end

  // Receive element count, same scheme as the transmit side
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_element_count <= CNT_ZERO; // RQ19
    end else if (!on || !deep) begin
      rx_element_count <= CNT_ZERO; // RQ19
    end else begin
      rx_element_count <= {1'b0, ptrs_i.shifter_write_pointer - ptrs_i.cpu_read_pointer}; // RQ1
    end
  end

  // Status word; unimplemented bits stay zero
  // Deep-mode flags follow the pointers with no delay, so a read sees the
  // buffer state of the strobe cycle; in standard mode the shifter empty
  // and receive empty bits read zero
  always_comb begin
    serial_port_status = WORD_ZERO; // RQ15
    serial_port_status[RXCNT_LSB +: CNT_W] = rx_element_count; // RQ1
    serial_port_status[TXCNT_LSB +: CNT_W] = tx_element_count; // RQ2
    serial_port_status[FRAME_ERROR_FLAG_BIT] = frame_error_flag;
    serial_port_status[BUSY_BIT] = ev_i.active || link_busy; // RQ4
    serial_port_status[TUR_BIT] = tx_underrun_flag;
    serial_port_status[ROV_BIT] = rx_overflow_flag;
    serial_port_status[TBE_BIT] = tx_buffer_empty_flag;
    if (deep) begin
      serial_port_status[SHIFTER_EMPTY_FLAG_BIT] = !ev_i.shifter_full; // RQ6
      serial_port_status[RBE_BIT] =
        (ptrs_i.cpu_read_pointer == ptrs_i.shifter_write_pointer); // RQ9
      serial_port_status[TBF_BIT] =
        ((ptrs_i.cpu_write_pointer + PTR_ONE) == ptrs_i.shifter_read_pointer); // RQ12
      serial_port_status[RBF_BIT] =
        ((ptrs_i.shifter_write_pointer + PTR_ONE) == ptrs_i.cpu_read_pointer); // RQ14
    end else begin
      serial_port_status[TBF_BIT] = tx_std_full; // RQ11
      serial_port_status[RBF_BIT] = rx_std_full; // RQ13
    end
  end

  // Interrupt events are the rising edges of the error flags: a flag that
  // stays set raises its sticky bit only once, so a write-one clear holds
  // until the event happens again
  assign irq_set = {frame_error_flag, tx_underrun_flag, rx_overflow_flag};
  assign irq_rise = irq_set & ~irq_prev;

  // Previous flag levels; reset matches the cleared flags, so no false edge
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_prev <= 3'h0;
    end else begin
      irq_prev <= irq_set;
    end
  end

  // Sticky interrupt status; set wins over a write-one clear
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= 3'h0;
    end else if (wr_i && (addr_i == IRQ_STATUS_ADDR)) begin
      irq_stat <= (irq_stat & ~wdata_i[IRQ_W-1:0]) | irq_rise;
    end else begin
      irq_stat <= irq_stat | irq_rise;
    end
  end

  // Interrupt mask, same layout as the status
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= 3'h0;
    end else if (wr_i && (addr_i == IRQ_MASK_ADDR)) begin
      irq_mask <= wdata_i[IRQ_W-1:0];
    end
  end

  // Level interrupt, one cycle behind status and mask
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  // Read port; status writes touch only clearable bits
  // Read data stand for exactly one cycle and fall back to zero, so a
  // master that samples late sees zero rather than a stale word
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= WORD_ZERO;
    end else if (rd_i) begin
      unique case (addr_i)
        STATUS_ADDR: rdata_o <= serial_port_status; // RQ18
        CONTROL_ADDR: rdata_o <= {27'h0000000, ctl};
        IRQ_STATUS_ADDR: rdata_o <= {29'h00000000, irq_stat};
        IRQ_MASK_ADDR: rdata_o <= {29'h00000000, irq_mask};
        default: rdata_o <= WORD_ZERO;
      endcase
    end else begin
      rdata_o <= WORD_ZERO;
    end
  end

  // Registered control outputs
  // Each lags its control bit, or the halt register, by one cycle, keeping every output on a flop
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      halt_o <= 1'b0;
      module_on_o <= 1'b0;
      deep_buffer_select_o <= 1'b0;
      framed_mode_enable_o <= 1'b0;
    end else begin
      halt_o <= halt;
      module_on_o <= on;
      deep_buffer_select_o <= deep;
      framed_mode_enable_o <= ctl[CTL_FRM_BIT];
    end
  end
endmodule : spi_status_flag_logic

// >>> sim/spi_flags_monitor.sv
`timescale 1ns/1ps
module spi_flags_monitor (
  input wire logic mclk_i, // Clock
  input wire logic resetn_i, // Reset, active low
  input wire logic [3:0] addr_i, // Register address
  input wire logic rd_i, // Read strobe
  input wire spi_flags_pkg::shift_events_t ev_i, // Datapath events
  input wire spi_flags_pkg::buf_ptrs_t ptrs_i, // Deep buffer pointers
  input wire logic [31:0] rdata_o, // Read data
  input wire logic halt_o, // Halted
  input wire logic module_on_o, // Enabled
  input wire logic deep_buffer_select_o // Deep buffer mode
);
  import spi_flags_pkg::*;
  logic srd;
  // Status read in this cycle
  assign srd = rd_i && addr_i == STATUS_ADDR;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  idle_zero_a: assert property (!$past(rd_i) |-> rdata_o == WORD_ZERO)
    else $error("read data not zero outside answer cycle");
  spare_bits_a: assert property ($past(srd) |-> (rdata_o & 32'hE0E0_E614) == WORD_ZERO)
    else $error("unused status bit set");
  rx_empty_a: assert property ($past(srd && deep_buffer_select_o) |-> rdata_o[RBE_BIT] ==
    ($past(ptrs_i.cpu_read_pointer) == $past(ptrs_i.shifter_write_pointer)))
    else $error("rx empty wrong");
  tx_full_a: assert property ($past(srd && deep_buffer_select_o) |-> rdata_o[TBF_BIT] ==
    ($past(ptrs_i.cpu_write_pointer) + PTR_ONE == $past(ptrs_i.shifter_read_pointer)))
    else $error("tx full wrong");
  rx_full_a: assert property ($past(srd && deep_buffer_select_o) |-> rdata_o[RBF_BIT] ==
    ($past(ptrs_i.shifter_write_pointer) + PTR_ONE == $past(ptrs_i.cpu_read_pointer)))
    else $error("rx full wrong");
  shift_empty_a: assert property ($past(srd && deep_buffer_select_o) |->
    rdata_o[SHIFTER_EMPTY_FLAG_BIT] == !$past(ev_i.shifter_full))
    else $error("shifter empty wrong");
  elem_counts_a: assert property ($past(srd && deep_buffer_select_o && module_on_o) &&
    $past(deep_buffer_select_o && module_on_o, 2) && $past(ptrs_i, 2) == $past(ptrs_i) |->
    rdata_o[28:24] == {1'b0, $past(ptrs_i.shifter_write_pointer - ptrs_i.cpu_read_pointer)} &&
    rdata_o[20:16] == {1'b0, $past(ptrs_i.cpu_write_pointer - ptrs_i.shifter_read_pointer)})
    else $error("element count wrong");
  counts_off_a: assert property ($past(srd && !module_on_o) && $past(!module_on_o, 2) |->
    rdata_o[28:16] == 13'h0000)
    else $error("count not zero while disabled");
  halt_off_a: assert property (!module_on_o [*2] |-> !halt_o)
    else $error("halt held while disabled");
  busy_lvl_a: assert property ($past(srd) && $past(ev_i.active) && $past(ev_i.active, 2) |->
    rdata_o[BUSY_BIT])
    else $error("busy low during activity");
endmodule : spi_flags_monitor

// >>> sim/spi_link_partner.sv
`timescale 1ns/1ps
module spi_link_partner (
  input wire logic frame_i, // Frame in progress
  output logic sck_o // Serial clock, still outside frames
);
  // 160 ns clock only inside a frame, phase off the system clock
  initial begin
    sck_o = 1'b0;
    forever begin
      wait (frame_i);
      #1.3;
      while (frame_i) #80 sck_o = ~sck_o;
    end
  end
endmodule : spi_link_partner

// >>> sim/spi_status_flag_logic_test.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module spi_status_flag_logic_test;
  import spi_flags_pkg::*;
  logic mclk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, data_wr_i = 0, data_rd_i = 0, frame = 0;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0000_0000, rdata_o, d;
  shift_events_t ev_i = '0;
  buf_ptrs_t ptrs_i = '0;
  logic sck, irq_o, halt_o, on_o, deep_o, fm_o, b;
  int bad_count = 0, n_compared = 0, cyc = 0;
  // Clock and the far-side link
  always #2 mclk_i = ~mclk_i;
  spi_link_partner i_link (.frame_i(frame), .sck_o(sck));
  spi_status_flag_logic i_dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .data_wr_i(data_wr_i), .data_rd_i(data_rd_i),
    .ev_i(ev_i), .ptrs_i(ptrs_i), .link_sck_i(sck), .rdata_o(rdata_o), .irq_o(irq_o),
    .halt_o(halt_o), .module_on_o(on_o), .deep_buffer_select_o(deep_o),
    .framed_mode_enable_o(fm_o));
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  // Hang guard
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    {wr_i, addr_i, wdata_i} <= {1'b1, a, v};
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a);
    @(posedge mclk_i);
    {rd_i, addr_i} <= {1'b1, a};
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd
  task st(input logic [31:0] e);
    rd(STATUS_ADDR);
    `CHK("status", e, d)
  endtask : st
  // Pulse data window strobes and datapath events
  task pls(input logic [8:0] v);
    @(posedge mclk_i);
    {data_wr_i, data_rd_i, ev_i} <= v;
    @(posedge mclk_i);
    {data_wr_i, data_rd_i, ev_i} <= 9'h000;
  endtask : pls
  task t_reset;
    st(32'h0000_0008);
    rd(4'h2);
    `CHK("unmapped", 32'h0000_0000, d)
  endtask : t_reset
  task t_std;
    wr(CONTROL_ADDR, 32'h0000_0001);
    pls(9'h100);
    st(32'h0000_0002);
    pls(9'h040);
    st(32'h0000_0008);
    pls(9'h020);
    pls(9'h010);
    st(32'h0000_0049);
    `CHK("halt", 1'b1, halt_o)
    `CHK("irq", 1'b0, irq_o)
    wr(STATUS_ADDR, 32'hFFFF_FFFF);
    st(32'h0000_0049);
    wr(IRQ_MASK_ADDR, 32'h0000_0001);
    repeat (2) @(posedge mclk_i);
    `CHK("irq", 1'b1, irq_o)
    wr(STATUS_ADDR, 32'h0000_0000);
    wr(IRQ_STATUS_ADDR, 32'h0000_0001);
    repeat (2) @(posedge mclk_i);
    `CHK("irq", 1'b0, irq_o)
    st(32'h0000_0009);
    pls(9'h080);
    st(32'h0000_0008);
  endtask : t_std
  task t_deep;
    wr(CONTROL_ADDR, 32'h0000_0000);
    ptrs_i <= {4'h2, 4'h5, 4'h3, 4'h4};
    wr(CONTROL_ADDR, 32'h0000_0003);
    st(32'h030F_008A);
    wr(CONTROL_ADDR, 32'h0000_0007);
    pls(9'h004);
    pls(9'h008);
    st(32'h030F_118A);
    `CHK("halt", 1'b1, halt_o)
    `CHK("framed", 1'b1, fm_o)
    `CHK("on", 1'b1, on_o)
    `CHK("deep", 1'b1, deep_o)
    wr(STATUS_ADDR, 32'h0000_0000);
    st(32'h030F_008A);
    wr(CONTROL_ADDR, 32'h0000_0000);
    st(32'h0000_0008);
    `CHK("halt", 1'b0, halt_o)
    // Deep receive buffer full, overflow ignored: flag set, no halt
    ptrs_i <= {4'h6, 4'h5, 4'h3, 4'h4};
    wr(CONTROL_ADDR, 32'h0000_000B);
    pls(9'h010);
    st(32'h0F0F_00CB);
    `CHK("halt_ign", 1'b0, halt_o)
    wr(CONTROL_ADDR, 32'h0000_0000);
  endtask : t_deep
  task t_busy;
    wr(CONTROL_ADDR, 32'h0000_0001);
    ev_i <= 7'h01;
    repeat (3) @(posedge mclk_i);
    rd(STATUS_ADDR);
    `CHK("busy", 1'b1, d[BUSY_BIT])
    ev_i <= 7'h00;
    frame <= 1'b1;
    b = 1'b0;
    repeat (60) begin
      rd(STATUS_ADDR);
      b = b | d[BUSY_BIT];
    end
    `CHK("busy_link", 1'b1, b)
    frame <= 1'b0;
    repeat (100) @(posedge mclk_i);
    rd(STATUS_ADDR);
    `CHK("busy_idle", 1'b0, d[BUSY_BIT])
  endtask : t_busy
  initial begin
    repeat (12) @(posedge mclk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    t_reset();
    t_std();
    t_deep();
    t_busy();
    final_report();
  end
endmodule : spi_status_flag_logic_test
bind spi_status_flag_logic spi_flags_monitor i_mon (.mclk_i(mclk_i), .resetn_i(resetn_i),
  .addr_i(addr_i), .rd_i(rd_i), .ev_i(ev_i), .ptrs_i(ptrs_i), .rdata_o(rdata_o),
  .halt_o(halt_o), .module_on_o(module_on_o), .deep_buffer_select_o(deep_buffer_select_o));
